// [gsn_pkg.sv]
package gsn_pkg;

  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int         GSN_AW         = 8;
  localparam int         GSN_DW         = 8;
  localparam int         GSN_NPLL       = 4;
  localparam int         GSN_SHADOW_AW  = 6;
  localparam int         GSN_SHADOW_N   = 64;
  localparam int         GSN_NLIVE      = 6;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] GSN_OFS_REV     = 8'h01;
  localparam logic [7:0] GSN_OFS_STAT1   = 8'h02;
  localparam logic [7:0] GSN_OFS_NOTIFY1 = 8'h03;
  localparam logic [7:0] GSN_OFS_MASK1   = 8'h04;
  localparam logic [7:0] GSN_OFS_DIR     = 8'h05;
  localparam logic [7:0] GSN_OFS_STAT2   = 8'h06;
  localparam logic [7:0] GSN_OFS_NOTIFY2 = 8'h07;
  localparam logic [7:0] GSN_OFS_MASK2   = 8'h08;
  localparam logic [7:0] GSN_OFS_SHADOW_LO = 8'h10;
  localparam logic [7:0] GSN_OFS_SHADOW_HI = 8'h4f;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int         GSN_BIT_CAL_DONE = 0;
  localparam int         GSN_BIT_REF_LOSS = 2;
  localparam int         GSN_BIT_DEC      = 0;
  localparam int         GSN_BIT_INC      = 1;
  localparam int         GSN_SEL_LO       = 2;
  localparam int         GSN_SEL_HI       = 3;
  localparam int         GSN_LIVE_UNLOCK  = 2;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] GSN_RST_STATUS  = 8'h00;
  localparam logic [7:0] GSN_RST_NOTIFY  = 8'hff;
  localparam logic [3:0] GSN_RST_NOTIFY2 = 4'hf;
  localparam logic [7:0] GSN_RST_MASK    = 8'hff;
  localparam logic [7:0] GSN_RST_DIR     = 8'h00;
  localparam logic [7:0] GSN_RD_ZERO     = 8'h00;

  // revision code: arbitrary neutral value
  localparam logic [7:0] GSN_REV_DEFAULT = 8'h5a;

endpackage

// [gsn_shadow_if.sv]
`timescale 1ns/100ps
interface gsn_shadow_if;
  import gsn_pkg::*;
  logic                     we;
  logic [GSN_SHADOW_AW-1:0] waddr;
  logic [GSN_DW-1:0]        wdata;
  logic                     re;
  logic [GSN_SHADOW_AW-1:0] raddr;
  logic [GSN_DW-1:0]        rdata;

  modport ctrl (output we, output waddr, output wdata, output re, output raddr, input rdata);
  modport mem  (input we, input waddr, input wdata, input re, input raddr, output rdata);
endinterface

// [gsn_shadow_mem.sv]
`timescale 1ns/100ps
module gsn_shadow_mem
  import gsn_pkg::*;
(
  // clock
  input wire logic clk,
  // access port
  gsn_shadow_if.mem port
);

  logic [GSN_DW-1:0] store [GSN_SHADOW_N];

  // ------------------------------------------------------------
  // write
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (port.we)
    begin
      store[port.waddr] <= port.wdata;
    end
  end

  // ------------------------------------------------------------
  // registered read
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (port.re)
    begin
      port.rdata <= store[port.raddr];
    end
  end

endmodule // gsn_shadow_mem

// [gsn_regs.sv]
// Behaviour
// - offsets 0x10 to 0x4f hold the volatile copy of stored settings
// - offset 0x01 returns a read-only revision code; writes ignored
// - status one bit 2 follows reference clock loss live
// - status one bit 0 shows rc calibration done live
// - notify one bit 2 is sticky reference clock loss, resets to one
// - mask one bit 2 at zero stops setting notify one bit 2; resets one
// - directive bits 3:2 pick the oscillator-control pll a to d
// - directive bit 1 requests one increment step; common when enable set
// - directive bit 0 requests one decrement step; common when enable set
// - status two bits 3:0 show live unlock of pll d,c,b,a
// - status bits and directive fields reset to zero
// - notify two bits 3:0 are sticky unlock copies, reset to one
// - mask two bit at zero stops setting matching notify two bit
`timescale 1ns/100ps
module gsn_regs
  import gsn_pkg::*;
#(
  parameter logic [7:0] REVISION = GSN_REV_DEFAULT
)
(
  // clock and reset
  input  wire logic                clk,
  input  wire logic                resetn,
  // register access
  input  wire logic                wr_en,
  input  wire logic                rd_en,
  input  wire logic [GSN_AW-1:0]   addr,
  input  wire logic [GSN_DW-1:0]   wdata,
  output logic      [GSN_DW-1:0]   rdata,
  output logic                     rd_valid,
  // live conditions from analog side
  input  wire logic                ref_clk_loss,
  input  wire logic                rc_cal_done,
  input  wire logic                first_pll_unlock,
  input  wire logic                second_pll_unlock,
  input  wire logic                third_pll_unlock,
  input  wire logic                fourth_pll_unlock,
  // common step enable from page register
  input  wire logic                common_step_en,
  // oscillator control
  output logic      [1:0]          dco_target,
  output logic      [GSN_NPLL-1:0] dco_step_up,
  output logic      [GSN_NPLL-1:0] dco_step_down
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [GSN_NPLL-1:0] step_vec(input logic [1:0] sel, input logic common);
    logic [GSN_NPLL-1:0] v;
    v = '0;
    v[sel] = 1'b1;
    return common ? {GSN_NPLL{1'b1}} : v;
  endfunction

  function automatic logic hit(input logic [GSN_AW-1:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic [GSN_NLIVE-1:0] raw;
  logic [GSN_NLIVE-1:0] sync1;
  logic [GSN_NLIVE-1:0] sync2;
  logic [GSN_NLIVE-1:0] sync3;
  logic [GSN_NLIVE-1:0] live;

  assign raw = {fourth_pll_unlock, third_pll_unlock, second_pll_unlock,
                first_pll_unlock, ref_clk_loss, rc_cal_done};

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end
    else
    begin
      sync1 <= raw;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // a change is taken once stages two and three agree
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      live <= '0;
    end
    else
    begin
      for (int i = 0; i < GSN_NLIVE; i++)
      begin
        if (sync2[i] == sync3[i])
        begin
          live[i] <= sync3[i];
        end
      end
    end
  end

  logic                ref_loss_live;
  logic                cal_done_live;
  logic [GSN_NPLL-1:0] unlock_live;

  assign cal_done_live = live[0];
  assign ref_loss_live = live[1];
  assign unlock_live   = live[GSN_LIVE_UNLOCK +: GSN_NPLL];

  // ------------------------------------------------------------
  // notify and mask registers
  // ------------------------------------------------------------
  logic [GSN_DW-1:0]   notify_one;
  logic [GSN_DW-1:0]   mask_one;
  logic [GSN_NPLL-1:0] notify_two;
  logic [GSN_DW-1:0]   mask_two;
  logic [GSN_DW-1:0]   directive;
  logic                wr_dir;

  assign wr_dir = wr_en && hit(addr, GSN_OFS_DIR);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mask_one <= GSN_RST_MASK;
      mask_two <= GSN_RST_MASK;
    end
    else if (wr_en)
    begin
      if (hit(addr, GSN_OFS_MASK1))
      begin
        mask_one <= wdata;
      end
      if (hit(addr, GSN_OFS_MASK2))
      begin
        mask_two <= wdata;
      end
    end
  end

  // spare bits store plainly; sticky bits clear by writing one, set wins
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      notify_one <= GSN_RST_NOTIFY;
    end
    else
    begin
      if (wr_en && hit(addr, GSN_OFS_NOTIFY1))
      begin
        notify_one <= wdata;
        notify_one[GSN_BIT_REF_LOSS] <= notify_one[GSN_BIT_REF_LOSS]
                                        & ~wdata[GSN_BIT_REF_LOSS];
      end
      if (ref_loss_live && mask_one[GSN_BIT_REF_LOSS])
      begin
        notify_one[GSN_BIT_REF_LOSS] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      notify_two <= GSN_RST_NOTIFY2;
    end
    else
    begin
      notify_two <= (notify_two & ~((wr_en && hit(addr, GSN_OFS_NOTIFY2)) ?
                                   wdata[GSN_NPLL-1:0] : '0))
                  | (unlock_live & mask_two[GSN_NPLL-1:0]);
    end
  end

  // ------------------------------------------------------------
  // oscillator directive
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      directive <= GSN_RST_DIR;
    end
    else if (wr_dir)
    begin
      directive <= wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dco_target    <= '0;
      dco_step_up   <= '0;
      dco_step_down <= '0;
    end
    else
    begin
      dco_target    <= directive[GSN_SEL_HI:GSN_SEL_LO];
      dco_step_up   <= (wr_dir && wdata[GSN_BIT_INC]) ?
                       step_vec(wdata[GSN_SEL_HI:GSN_SEL_LO], common_step_en) : '0;
      dco_step_down <= (wr_dir && wdata[GSN_BIT_DEC]) ?
                       step_vec(wdata[GSN_SEL_HI:GSN_SEL_LO], common_step_en) : '0;
    end
  end

  // ------------------------------------------------------------
  // stored settings shadow
  // ------------------------------------------------------------
  gsn_shadow_if shadow ();

  logic in_shadow;

  assign in_shadow    = (addr >= GSN_OFS_SHADOW_LO) && (addr <= GSN_OFS_SHADOW_HI);
  assign shadow.we    = wr_en && in_shadow;
  assign shadow.waddr = GSN_SHADOW_AW'(addr - GSN_OFS_SHADOW_LO);
  assign shadow.wdata = wdata;
  assign shadow.re    = rd_en && in_shadow;
  assign shadow.raddr = GSN_SHADOW_AW'(addr - GSN_OFS_SHADOW_LO);

  gsn_shadow_mem u_shadow (
    .clk  (clk),
    .port (shadow)
  );

  // ------------------------------------------------------------
  // read path: two cycles for every address
  // ------------------------------------------------------------
  logic [GSN_DW-1:0] next_rd;
  logic [GSN_DW-1:0] rd_hold;
  logic              rd_pend;
  logic              rd_from_mem;

  always_comb
  begin
    next_rd = GSN_RD_ZERO;
    unique case (addr)
      GSN_OFS_REV:     next_rd = REVISION;
      GSN_OFS_STAT1:
      begin
        next_rd[GSN_BIT_REF_LOSS] = ref_loss_live;
        next_rd[GSN_BIT_CAL_DONE] = cal_done_live;
      end
      GSN_OFS_NOTIFY1: next_rd = notify_one;
      GSN_OFS_MASK1:   next_rd = mask_one;
      GSN_OFS_DIR:     next_rd = directive;
      GSN_OFS_STAT2:   next_rd[GSN_NPLL-1:0] = unlock_live;
      GSN_OFS_NOTIFY2: next_rd[GSN_NPLL-1:0] = notify_two;
      GSN_OFS_MASK2:   next_rd = mask_two;
      default:         next_rd = GSN_RD_ZERO;
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_hold     <= GSN_RD_ZERO;
      rd_pend     <= 1'b0;
      rd_from_mem <= 1'b0;
    end
    else
    begin
      rd_pend <= rd_en;
      if (rd_en)
      begin
        rd_hold     <= next_rd;
        rd_from_mem <= in_shadow;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdata    <= GSN_RD_ZERO;
      rd_valid <= 1'b0;
    end
    else
    begin
      rd_valid <= rd_pend;
      if (rd_pend)
      begin
        rdata <= rd_from_mem ? shadow.rdata : rd_hold;
      end
    end
  end

endmodule // gsn_regs

// [gsn_regs_checker.sv]
`timescale 1ns/100ps
module gsn_regs_checker
  import gsn_pkg::*;
#(
  parameter logic [7:0] REVISION = GSN_REV_DEFAULT
)
(
  // clock and reset
  input wire logic                clk,
  input wire logic                resetn,
  // register access
  input wire logic                wr_en,
  input wire logic                rd_en,
  input wire logic [GSN_AW-1:0]   addr,
  input wire logic [GSN_DW-1:0]   wdata,
  input wire logic [GSN_DW-1:0]   rdata,
  input wire logic                rd_valid,
  // live conditions and step enable
  input wire logic                ref_clk_loss,
  input wire logic                rc_cal_done,
  input wire logic                first_pll_unlock,
  input wire logic                second_pll_unlock,
  input wire logic                third_pll_unlock,
  input wire logic                fourth_pll_unlock,
  input wire logic                common_step_en,
  // oscillator control
  input wire logic [1:0]          dco_target,
  input wire logic [GSN_NPLL-1:0] dco_step_up,
  input wire logic [GSN_NPLL-1:0] dco_step_down
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  logic [1:0] sel_d1;
  logic [1:0] sel_d2;
  logic       dir_wr_d;

  // ------------------------------------------------------------
  // delayed copies of directive writes
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    sel_d1   <= wdata[3:2];
    sel_d2   <= sel_d1;
    dir_wr_d <= wr_en && (addr == GSN_OFS_DIR);
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  AST_RD_LAT: assert property (rd_en |-> ##2 rd_valid)
    else $error("read answer missing two cycles after request");
  AST_RD_CAUSE: assert property (rd_valid |-> $past(rd_en, 2))
    else $error("read answer without request");
  AST_REV: assert property (rd_en && addr == GSN_OFS_REV |-> ##2 rdata == REVISION)
    else $error("revision read wrong");
  AST_UNMAPPED: assert property (rd_en && (addr == 8'h00 || addr inside {[8'h09:8'h0f]}
    || addr > GSN_OFS_SHADOW_HI) |-> ##2 rdata == GSN_RD_ZERO)
    else $error("unmapped read not zero");
  AST_RESV: assert property (rd_en && (addr == GSN_OFS_STAT2 || addr == GSN_OFS_NOTIFY2)
    |-> ##2 rdata[7:4] == 4'h0)
    else $error("reserved nibble not zero");
  AST_STEP_ALL: assert property (wr_en && addr == GSN_OFS_DIR && wdata[1] && common_step_en
    |=> dco_step_up == 4'hf)
    else $error("common increment not on all plls");
  AST_STEP_ONE: assert property (wr_en && addr == GSN_OFS_DIR && wdata[0] && !common_step_en
    |=> dco_step_down == (4'h1 << sel_d1))
    else $error("decrement not on selected pll");
  AST_NO_STEP: assert property (dco_step_up != 4'h0 || dco_step_down != 4'h0 |-> dir_wr_d)
    else $error("step pulse without directive write");
  AST_TARGET: assert property (wr_en && addr == GSN_OFS_DIR |-> ##2 dco_target == sel_d2)
    else $error("target does not follow directive");
  AST_RESET: assert property ($rose(resetn) |-> !rd_valid && dco_step_up == 4'h0
    && dco_step_down == 4'h0 && dco_target == 2'h0)
    else $error("outputs not idle after reset");

  cover property (rd_en && addr == GSN_OFS_REV);
  cover property (dco_step_up == 4'hf);
  cover property (rd_valid && rdata != 8'h00);
endmodule // gsn_regs_checker

bind gsn_regs gsn_regs_checker #(.REVISION(REVISION)) chk_u (
  .clk(clk), .resetn(resetn), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
  .wdata(wdata), .rdata(rdata), .rd_valid(rd_valid), .ref_clk_loss(ref_clk_loss),
  .rc_cal_done(rc_cal_done), .first_pll_unlock(first_pll_unlock),
  .second_pll_unlock(second_pll_unlock), .third_pll_unlock(third_pll_unlock),
  .fourth_pll_unlock(fourth_pll_unlock), .common_step_en(common_step_en),
  .dco_target(dco_target), .dco_step_up(dco_step_up), .dco_step_down(dco_step_down));

// [gsn_host.sv]
`timescale 1ns/100ps
module gsn_host
  import gsn_pkg::*;
(
  // clock
  input  wire logic              clk,
  // register access
  output logic                   wr_en,
  output logic                   rd_en,
  output logic      [GSN_AW-1:0] addr,
  output logic      [GSN_DW-1:0] wdata,
  input  wire logic [GSN_DW-1:0] rdata,
  input  wire logic              rd_valid
);
  initial
  begin
    wr_en = 1'h0;
    rd_en = 1'h0;
    addr  = 8'h00;
    wdata = 8'h00;
  end

  // one write, held over one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    addr  = a;
    wdata = d;
    wr_en = 1'h1;
    @(posedge clk);
    #1;
    wr_en = 1'h0;
  endtask

  // one read; answer taken within four edges
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    d = 8'hxx;
    @(posedge clk);
    #1;
    addr  = a;
    rd_en = 1'h1;
    @(posedge clk);
    #1;
    rd_en = 1'h0;
    repeat (4)
    begin
      @(posedge clk);
      #1;
      if (rd_valid === 1'h1)
        d = rdata;
    end
  endtask
endmodule // gsn_host

// [gsn_regs_bench.sv]
`timescale 1ns/100ps
module gsn_regs_bench
  import gsn_pkg::*;
;
  // revision: arbitrary value
  localparam logic [7:0] REV = 8'h3c;
  localparam logic [7:0] RA [10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04,
                                     8'h05, 8'h06, 8'h07, 8'h08, 8'h09};
  localparam logic [7:0] RE [10] = '{8'h00, REV, 8'h00, 8'hff, 8'hff,
                                     8'h00, 8'h00, 8'h0f, 8'hff, 8'h00};
  logic       clk;
  logic       resetn;
  logic       wr_en;
  logic       rd_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       rd_valid;
  logic       loss;
  logic       cal;
  logic [3:0] unl;
  logic       cmn;
  logic [1:0] tgt;
  logic [3:0] up;
  logic [3:0] dn;
  int         fails;
  int         n_checks;

  gsn_regs #(.REVISION(REV)) dut_u (
    .clk(clk), .resetn(resetn), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wdata(wdata), .rdata(rdata), .rd_valid(rd_valid), .ref_clk_loss(loss),
    .rc_cal_done(cal), .first_pll_unlock(unl[0]), .second_pll_unlock(unl[1]),
    .third_pll_unlock(unl[2]), .fourth_pll_unlock(unl[3]), .common_step_en(cmn),
    .dco_target(tgt), .dco_step_up(up), .dco_step_down(dn));
  gsn_host host_u (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wdata(wdata), .rdata(rdata), .rd_valid(rd_valid));

  initial
  begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic close_out;
    if (fails == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      fails++;
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    logic [7:0] d;
    host_u.rd(a, d);
    chk(d & m, e);
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic run_rows;
    for (int i = 0; i < 10; i++)
      rdchk(RA[i], RE[i], 8'hff);
  endtask

  initial
  begin
    #20000;
    fails++;
    close_out;
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    fails = 0;
    n_checks = 0;
    resetn = 1'h0;
    {loss, cal, unl, cmn} = 7'h00;
    wait_n(2);
    resetn = 1'h1;
    run_rows;
    host_u.wr(8'h01, 8'h00);
    rdchk(8'h01, REV, 8'hff);
    host_u.wr(8'h10, 8'ha5);
    host_u.wr(8'h4f, 8'h96);
    rdchk(8'h10, 8'ha5, 8'hff);
    rdchk(8'h4f, 8'h96, 8'hff);
    {loss, cal, unl} = 6'h35;
    wait_n(6);
    rdchk(8'h02, 8'h05, 8'hff);
    rdchk(8'h06, 8'h05, 8'hff);
    {loss, unl} = 5'h00;
    wait_n(6);
    host_u.wr(8'h04, 8'h00);
    host_u.wr(8'h03, 8'h04);
    rdchk(8'h03, 8'h00, 8'h04);
    loss = 1'h1;
    wait_n(6);
    rdchk(8'h03, 8'h00, 8'h04);
    host_u.wr(8'h04, 8'h04);
    wait_n(2);
    loss = 1'h0;
    wait_n(6);
    rdchk(8'h03, 8'h04, 8'h04);
    host_u.wr(8'h03, 8'h04);
    rdchk(8'h03, 8'h00, 8'h04);
    host_u.wr(8'h07, 8'h0f);
    rdchk(8'h07, 8'h00, 8'hff);
    host_u.wr(8'h08, 8'h0a);
    unl = 4'hf;
    wait_n(6);
    rdchk(8'h07, 8'h0a, 8'hff);
    rdchk(8'h06, 8'h0f, 8'hff);
    unl = 4'h0;
    for (int t = 0; t < 4; t++)
    begin
      host_u.wr(8'h05, {4'h0, t[1:0], 2'h3});
      chk({4'h0, up}, 8'h01 << t);
      chk({4'h0, dn}, 8'h01 << t);
      wait_n(1);
      chk({6'h00, tgt}, t[7:0]);
    end
    cmn = 1'h1;
    host_u.wr(8'h05, 8'h02);
    chk({up, dn}, 8'hf0);
    cmn = 1'h0;
    rdchk(8'h05, 8'h02, 8'hff);
    // quiet live inputs so the post-reset rows read zero status
    {loss, cal, unl, cmn} = 7'h00;
    resetn = 1'h0;
    wait_n(2);
    resetn = 1'h1;
    run_rows;
    close_out;
  end
endmodule // gsn_regs_bench
